// ---- include/ccst_pkg.sv ----
/*
  Shared constants and types of the control-channel supervision block:
  register indices, field positions, reset values, divider encoding and
  channel states. Assumes it is compiled before every other file.
*/
`default_nettype none

package ccst_pkg;

  // Register access port widths
  localparam int REG_IW = 4;
  localparam int REG_DW = 10;
  localparam int GPIO_N = 10;

  // Register indices
  localparam logic [REG_IW-1:0] IDX_WORD_WIDTH = 4'h1;
  localparam logic [REG_IW-1:0] IDX_START_CFG  = 4'h2;
  localparam logic [REG_IW-1:0] IDX_END_CFG    = 4'h3;
  localparam logic [REG_IW-1:0] IDX_MODE       = 4'h8;
  localparam logic [REG_IW-1:0] IDX_GPIO_DIR   = 4'h9;
  localparam logic [REG_IW-1:0] IDX_GPIO_LVL   = 4'hA;
  localparam logic [REG_IW-1:0] IDX_DRIVE      = 4'hC;

  // Field positions
  localparam int MODE_PROTO_BIT = 7;
  localparam int MODE_PASS_BIT  = 6;
  localparam int MODE_VRISE_BIT = 3;
  localparam int MODE_CTO_LSB   = 0;
  localparam int CTO_CODE_W     = 3;
  localparam int CFG_DIV_LSB    = 4;
  localparam int CFG_LIM_LSB    = 0;
  localparam int CFG_FIELD_W    = 4;
  localparam int DRIVE_LSB      = 5;
  localparam int DRIVE_W        = 3;
  localparam int WIDTH_W        = 3;

  // Reset values
  localparam logic [7:0] START_CFG_RST = 8'hA0;
  localparam logic [7:0] END_CFG_RST   = 8'hA0;
  localparam logic [7:0] MODE_RST      = 8'h80;
  localparam logic [7:0] DRIVE_RST     = 8'h00;
  localparam logic [WIDTH_W-1:0] WIDTH_RST     = 3'h4;
  localparam logic [WIDTH_W-1:0] WIDTH_CODE_MAX = 3'h4;
  localparam logic [3:0] GPIO_STEP = 4'h2;

  // Timeout divider: flat ratio up to the knee code, doubling above
  localparam int PRE_W = 16;
  localparam int CNT_W = 5;
  localparam logic [PRE_W-1:0] DIV_MIN       = 16'h0010;
  localparam logic [3:0]       DIV_FLAT_CODE = 4'h4;

  // Comeback timer: UART bit times per code step
  localparam int CTO_W = 7;
  localparam logic [CTO_W-1:0] CTO_UNIT = 7'h10;

  typedef enum logic [1:0] {
    CH_IDLE,
    CH_WAIT_HOST,
    CH_HOST_ACTIVE
  } ccst_chan_e;

endpackage

`default_nettype wire

// ---- include/ccst_tmr_if.sv ----
/*
  Control and status link between the channel controller and one
  timeout timer. Assumes one clock shared by both ends.
*/
`default_nettype none

interface ccst_tmr_if;
  logic       clear;
  logic       run;
  logic [3:0] divCode;
  logic [3:0] limit;
  logic       expired;

  modport ctrl (output clear, run, divCode, limit, input expired);
  modport tmr  (input clear, run, divCode, limit, output expired);
endinterface

`default_nettype wire

// ---- rtl/ccst_control.sv ----
/*
  Control-channel supervisor: channel open and close with start and end
  timeouts, base and bypass mode with comeback timer, packet steering,
  general purpose pins and open-drain status pins. Assumes a UART packet
  decoder on the same clock supplies register accesses and activity
  pulses; pins vsyncPin and gpioIn come from outside the clock domain.
*/
`default_nettype none

// Operation
// - Each general purpose pin is an output driver or a sampled input.
// - In input mode the level bit holds and returns the sampled pin.
// - Usable pins follow word width: 18 gives 8-9, 10 gives 0-9.
// - Fault pin pulls low on error, otherwise released.
// - Sync pin released while locked, for as long as lock holds.
// - Shutdown releases both status pins; observer ignores sync then.
// - Base mode turns packets for no link device into I2C requests.
// - Base mode turns peripheral I2C replies into UART replies.
// - Pass enable clear blocks peripheral traffic; base mode at reset.
// - Protocol select 1 means I2C base mode, 0 means UART bypass.
// - Comeback timeout in bypass clears pass enable, back to base.
// - Start timeout closes the channel if the host never speaks.
// - Start divider: 16 up to code 4, doubling to 32768 at 15.
// - Start counter ticks per divided period, expires at limit+1.
// - Start defaults: divider 1024, limit 0.
// - Host activity stops start timer and starts end timer.
// - End timeout closes the channel after a silent host.
// - End divider uses the start divider encoding.
// - End counter ticks per divided period, expires at limit+1.
// - Every host activity clears the end counter.
// - End defaults: divider 1024, limit 0.
// - Comeback code 0 never expires; else 16 times code bit times.
// - Channel opens on the active vsync edge, falling by default.
// - Closing frame in base mode closes the channel at once.
module ccst_control
  import ccst_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              ce,
  input  wire logic              regWrEn,
  input  wire logic [REG_IW-1:0] regIdx,
  input  wire logic [REG_DW-1:0] regWrData,
  output var  logic [REG_DW-1:0] regRdData,
  input  wire logic              vsyncPin,
  input  wire logic              hostActivity,
  input  wire logic              closingFrame,
  input  wire logic              pktValid,
  input  wire logic              pktToLink,
  input  wire logic              periphRspValid,
  input  wire logic              uartBitTick,
  input  wire logic              linkLocked,
  input  wire logic              errorFlag,
  input  wire logic              shutdown,
  input  wire logic [GPIO_N-1:0] gpioIn,
  output var  logic              ccen,
  output var  logic              i2cReqValid,
  output var  logic              uartFwdValid,
  output var  logic              uartRspValid,
  output var  logic              bypassMode,
  output var  logic [DRIVE_W-1:0] driveBoost,
  output var  logic              lockOut,
  output var  logic              lockOe,
  output var  logic              errOut,
  output var  logic              errOe,
  output var  logic [GPIO_N-1:0] gpioOut,
  output var  logic [GPIO_N-1:0] gpioOe
);

  localparam logic [CTO_W-1:0] CTO_ONE = 7'h01;

  typedef struct packed {
    ccst_chan_e        chan;
    logic              tmrClr;
    logic [7:0]        startCfg;
    logic [7:0]        endCfg;
    logic [7:0]        mode;
    logic [7:0]        drive;
    logic [WIDTH_W-1:0] width;
    logic [GPIO_N-1:0] gpDir;
    logic [GPIO_N-1:0] gpLvl;
    logic              vs1;
    logic              vs2;
    logic              vs3;
    logic              vsStable;
    logic [GPIO_N-1:0] gp1;
    logic [GPIO_N-1:0] gp2;
    logic [GPIO_N-1:0] gp3;
    logic [GPIO_N-1:0] gpStable;
    logic [CTO_W-1:0]  cto;
    logic [REG_DW-1:0] rdData;
    logic              ccen;
    logic              i2cReq;
    logic              uartFwd;
    logic              uartRsp;
    logic              lockOe;
    logic              errOe;
    logic [GPIO_N-1:0] gpOut;
    logic [GPIO_N-1:0] gpOe;
    logic              byp;
    logic              odLow;
  } ccst_state_s;

  ccst_state_s st_ff;
  ccst_state_s nxt_st;
  ccst_tmr_if  startIf ();
  ccst_tmr_if  endIf ();

  logic                  passEn;
  logic                  protoI2c;
  logic                  bypass;
  logic                  vsEdge;
  logic                  activity;
  logic [GPIO_N-1:0]     avail;
  logic [WIDTH_W-1:0]    wcode;
  logic [CTO_CODE_W-1:0] ctoCode;
  logic [CTO_W-1:0]      ctoLimit;

  // Timer controls come from registered state
  assign startIf.clear   = st_ff.tmrClr;
  assign startIf.run     = (st_ff.chan == CH_WAIT_HOST);
  assign startIf.divCode = st_ff.startCfg[CFG_DIV_LSB +: CFG_FIELD_W];
  assign startIf.limit   = st_ff.startCfg[CFG_LIM_LSB +: CFG_FIELD_W];
  assign endIf.clear     = st_ff.tmrClr;
  assign endIf.run       = (st_ff.chan == CH_HOST_ACTIVE);
  assign endIf.divCode   = st_ff.endCfg[CFG_DIV_LSB +: CFG_FIELD_W];
  assign endIf.limit     = st_ff.endCfg[CFG_LIM_LSB +: CFG_FIELD_W];

  ccst_timeout_timer uStartTmr (
    .clk  (clk),
    .rstn (rstn),
    .ce   (ce),
    .tmr  (startIf)
  );

  ccst_timeout_timer uEndTmr (
    .clk  (clk),
    .rstn (rstn),
    .ce   (ce),
    .tmr  (endIf)
  );

  // Next-state logic for the whole block
  always_comb begin
    nxt_st = st_ff;

    // Three-stage pin synchronisers, value taken when stages 2 and 3 agree
    nxt_st.vs1 = vsyncPin;
    nxt_st.vs2 = st_ff.vs1;
    nxt_st.vs3 = st_ff.vs2;
    if (st_ff.vs2 == st_ff.vs3) begin
      nxt_st.vsStable = st_ff.vs3;
    end
    nxt_st.gp1 = gpioIn;
    nxt_st.gp2 = st_ff.gp1;
    nxt_st.gp3 = st_ff.gp2;
    nxt_st.gpStable = (st_ff.gp3 & ~(st_ff.gp2 ^ st_ff.gp3))
                    | (st_ff.gpStable & (st_ff.gp2 ^ st_ff.gp3));

    // Mode decode
    passEn   = st_ff.mode[MODE_PASS_BIT];
    protoI2c = st_ff.mode[MODE_PROTO_BIT];
    bypass   = passEn && !protoI2c;
    ctoCode  = st_ff.mode[MODE_CTO_LSB +: CTO_CODE_W];
    ctoLimit = CTO_W'(ctoCode) * CTO_UNIT;

    // Active vsync edge, polarity selectable, falling after reset
    vsEdge = (st_ff.vs2 == st_ff.vs3) && (st_ff.vs3 != st_ff.vsStable)
          && (st_ff.vs3 == st_ff.mode[MODE_VRISE_BIT]);
    activity = hostActivity || (bypass && periphRspValid);

    // Pins usable for the current word width
    wcode = (st_ff.width > WIDTH_CODE_MAX) ? WIDTH_CODE_MAX : st_ff.width;
    for (int i = 0; i < GPIO_N; i++) begin
      avail[i] = (4'(i) >= GPIO_STEP * 4'(wcode));
    end

    // Comeback timer in bypass, host silence counted in UART bit times
    if (!bypass) begin
      nxt_st.cto = '0;
    end else if (hostActivity) begin
      nxt_st.cto = '0;
    end else if (uartBitTick && ctoCode != '0) begin
      if (st_ff.cto + CTO_ONE == ctoLimit) begin
        nxt_st.mode[MODE_PASS_BIT] = 1'b0;
        nxt_st.cto = '0;
      end else begin
        nxt_st.cto = st_ff.cto + CTO_ONE;
      end
    end

    // Register writes, ignored while in bypass
    if (regWrEn && !bypass) begin
      if (regIdx == IDX_WORD_WIDTH) begin
        nxt_st.width = regWrData[WIDTH_W-1:0];
      end else if (regIdx == IDX_START_CFG) begin
        nxt_st.startCfg = regWrData[7:0];
      end else if (regIdx == IDX_END_CFG) begin
        nxt_st.endCfg = regWrData[7:0];
      end else if (regIdx == IDX_MODE) begin
        nxt_st.mode = regWrData[7:0];
      end else if (regIdx == IDX_GPIO_DIR) begin
        nxt_st.gpDir = regWrData;
      end else if (regIdx == IDX_GPIO_LVL) begin
        nxt_st.gpLvl = regWrData;
      end else if (regIdx == IDX_DRIVE) begin
        nxt_st.drive = regWrData[7:0];
      end
    end

    // Registered copy of the mode decode drives the bypass output
    nxt_st.byp = nxt_st.mode[MODE_PASS_BIT] && !nxt_st.mode[MODE_PROTO_BIT];

    // Input pins overwrite their level bits with the sampled pin
    nxt_st.gpLvl = (nxt_st.gpLvl & st_ff.gpDir)
                 | (st_ff.gpStable & ~st_ff.gpDir);
    nxt_st.gpOe  = st_ff.gpDir & avail;
    nxt_st.gpOut = st_ff.gpLvl & st_ff.gpDir & avail;

    // Channel state machine
    nxt_st.tmrClr = 1'b0;
    case (st_ff.chan)
      CH_IDLE: begin
        if (vsEdge) begin
          nxt_st.chan   = CH_WAIT_HOST;
          nxt_st.tmrClr = 1'b1;
        end
      end
      CH_WAIT_HOST: begin
        if (startIf.expired) begin
          nxt_st.chan   = CH_IDLE;
          nxt_st.tmrClr = 1'b1;
        end else if (closingFrame && !bypass) begin
          nxt_st.chan   = CH_IDLE;
          nxt_st.tmrClr = 1'b1;
        end else if (activity) begin
          nxt_st.chan   = CH_HOST_ACTIVE;
          nxt_st.tmrClr = 1'b1;
        end
      end
      CH_HOST_ACTIVE: begin
        if (endIf.expired) begin
          nxt_st.chan   = CH_IDLE;
          nxt_st.tmrClr = 1'b1;
        end else if (closingFrame && !bypass) begin
          nxt_st.chan   = CH_IDLE;
          nxt_st.tmrClr = 1'b1;
        end else if (activity) begin
          nxt_st.tmrClr = 1'b1;
        end
      end
      default: begin
        nxt_st.chan = CH_IDLE;
      end
    endcase
    nxt_st.ccen = (nxt_st.chan != CH_IDLE);

    // Packet steering between host, link devices and peripheral
    nxt_st.i2cReq  = pktValid && !pktToLink && passEn && protoI2c;
    nxt_st.uartFwd = pktValid && bypass;
    nxt_st.uartRsp = periphRspValid && passEn && protoI2c;

    // Open-drain status pins, both released in shutdown
    nxt_st.lockOe = !linkLocked && !shutdown;
    nxt_st.errOe  = errorFlag && !shutdown;
    nxt_st.odLow  = 1'b0;  // Driven level is always low

    // Register read-back, zero in bypass and for unused indices
    nxt_st.rdData = '0;
    if (!bypass) begin
      if (regIdx == IDX_WORD_WIDTH) begin
        nxt_st.rdData = REG_DW'(st_ff.width);
      end else if (regIdx == IDX_START_CFG) begin
        nxt_st.rdData = REG_DW'(st_ff.startCfg);
      end else if (regIdx == IDX_END_CFG) begin
        nxt_st.rdData = REG_DW'(st_ff.endCfg);
      end else if (regIdx == IDX_MODE) begin
        nxt_st.rdData = REG_DW'(st_ff.mode);
      end else if (regIdx == IDX_GPIO_DIR) begin
        nxt_st.rdData = st_ff.gpDir & avail;
      end else if (regIdx == IDX_GPIO_LVL) begin
        nxt_st.rdData = st_ff.gpLvl & avail;
      end else if (regIdx == IDX_DRIVE) begin
        nxt_st.rdData = REG_DW'(st_ff.drive);
      end
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_ff          <= '0;
      st_ff.chan     <= CH_IDLE;
      st_ff.startCfg <= START_CFG_RST;
      st_ff.endCfg   <= END_CFG_RST;
      st_ff.mode     <= MODE_RST;
      st_ff.drive    <= DRIVE_RST;
      st_ff.width    <= WIDTH_RST;
      st_ff.vs1      <= 1'b1;  // Idle-high stages, no false edge
      st_ff.vs2      <= 1'b1;
      st_ff.vs3      <= 1'b1;
      st_ff.vsStable <= 1'b1;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign regRdData    = st_ff.rdData;
  assign ccen         = st_ff.ccen;
  assign i2cReqValid  = st_ff.i2cReq;
  assign uartFwdValid = st_ff.uartFwd;
  assign uartRspValid = st_ff.uartRsp;
  assign bypassMode   = st_ff.byp;
  assign driveBoost   = st_ff.drive[DRIVE_LSB +: DRIVE_W];
  assign lockOut      = st_ff.odLow;
  assign lockOe       = st_ff.lockOe;
  assign errOut       = st_ff.odLow;
  assign errOe        = st_ff.errOe;
  assign gpioOut      = st_ff.gpOut;
  assign gpioOe       = st_ff.gpOe;

endmodule

`default_nettype wire

// ---- rtl/ccst_timeout_timer.sv ----
/*
  One timeout timer: a programmable prescaler of the pixel clock feeding
  a small counter that expires at limit plus one. Assumes clear and run
  come from the controller on the same clock.
*/
`default_nettype none

module ccst_timeout_timer
  import ccst_pkg::*;
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic ce,
  ccst_tmr_if.tmr   tmr
);

  localparam logic [PRE_W-1:0] PRE_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;

  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [CNT_W-1:0] cnt;
    logic             expired;
  } ccst_tmr_s;

  ccst_tmr_s        st_ff;
  ccst_tmr_s        nxt_st;
  logic [PRE_W-1:0] ratio;

  // Prescaler and period counter
  always_comb begin
    nxt_st = st_ff;
    if (tmr.divCode <= DIV_FLAT_CODE) begin
      ratio = DIV_MIN;
    end else begin
      ratio = DIV_MIN << (tmr.divCode - DIV_FLAT_CODE);
    end
    if (tmr.clear) begin
      nxt_st = '0;
    end else if (tmr.run && !st_ff.expired) begin
      if (st_ff.pre == ratio - PRE_ONE) begin
        nxt_st.pre = '0;
        nxt_st.cnt = st_ff.cnt + CNT_ONE;
        if (st_ff.cnt + CNT_ONE == {1'b0, tmr.limit} + CNT_ONE) begin
          nxt_st.expired = 1'b1;
        end
      end else begin
        nxt_st.pre = st_ff.pre + PRE_ONE;
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign tmr.expired = st_ff.expired;

endmodule

`default_nettype wire

// ---- testbench/ccst_control_asserts.sv ----
/*
  Port checker of the control-channel supervisor.
  Assumes it is bound to ccst_control and sees its ports only.
*/
`default_nettype none

module ccst_control_asserts (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       ce,
  input wire logic       linkLocked,
  input wire logic       errorFlag,
  input wire logic       shutdown,
  input wire logic       pktValid,
  input wire logic       pktToLink,
  input wire logic       periphRspValid,
  input wire logic       hostActivity,
  input wire logic       closingFrame,
  input wire logic       ccen,
  input wire logic       i2cReqValid,
  input wire logic       uartFwdValid,
  input wire logic       uartRspValid,
  input wire logic       bypassMode,
  input wire logic       lockOut,
  input wire logic       lockOe,
  input wire logic       errOut,
  input wire logic       errOe,
  input wire logic [9:0] regRdData
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // Status pins follow their causes one cycle later
  property p_lock;
    $past(rstn) && $past(ce) |-> lockOe == $past(!linkLocked && !shutdown);
  endproperty
  a_lock: assert property (p_lock)
    else $error("lockOe wrong");
  property p_err;
    $past(rstn) && $past(ce) |-> errOe == $past(errorFlag && !shutdown);
  endproperty
  a_err: assert property (p_err)
    else $error("errOe wrong");
  property p_od;
    !lockOut && !errOut;
  endproperty
  a_od: assert property (p_od)
    else $error("open-drain value high");

  // Steering pulses need their cause in the right mode
  property p_i2c;
    i2cReqValid && $past(ce)
      |-> $past(pktValid && !pktToLink && !bypassMode);
  endproperty
  a_i2c: assert property (p_i2c)
    else $error("stray peripheral request");
  property p_fwd;
    uartFwdValid && $past(ce) |-> $past(pktValid && bypassMode);
  endproperty
  a_fwd: assert property (p_fwd)
    else $error("stray forward");
  property p_rsp;
    uartRspValid && $past(ce) |-> $past(periphRspValid && !bypassMode);
  endproperty
  a_rsp: assert property (p_rsp)
    else $error("stray reply");
  property p_bypRd;
    bypassMode && $past(bypassMode) |-> regRdData == '0;
  endproperty
  a_bypRd: assert property (p_bypRd)
    else $error("register read in bypass");

  // Channel closing and keeping
  property p_efClose;
    closingFrame && ccen && !bypassMode |-> ##[1:3] !ccen;
  endproperty
  a_efClose: assert property (p_efClose)
    else $error("closing frame ignored");
  property p_keep;
    hostActivity && ccen |=> (ccen[*8]) or (##[0:7] closingFrame);
  endproperty
  a_keep: assert property (p_keep)
    else $error("channel closed after activity");

  c_open: cover property ($rose(ccen));
  c_i2c: cover property (i2cReqValid);
  c_back: cover property ($fell(bypassMode));
endmodule

bind ccst_control ccst_control_asserts u_ccst_control_asserts (
  .clk, .rstn, .ce, .linkLocked, .errorFlag, .shutdown, .pktValid, .pktToLink,
  .periphRspValid, .hostActivity, .closingFrame, .ccen, .i2cReqValid,
  .uartFwdValid, .uartRspValid, .bypassMode, .lockOut, .lockOe, .errOut,
  .errOe, .regRdData
);

`default_nettype wire

// ---- testbench/ccst_host_model.sv ----
/*
  Host controller model: vsync edges, activity and packet strobes, and
  the pulled-up wired status lines. Assumes one clock shared with the block.
*/
`default_nettype none

module ccst_host_model (
  input  wire logic       clk,
  input  wire logic       lockOe,
  input  wire logic       errOe,
  output var  logic       lockLine,
  output var  logic       errLine,
  output var  logic       vsyncPin,
  output var  logic       pktToLink,
  output var  logic [4:0] strobe
);
  timeunit 1ns;
  timeprecision 1ns;

  // Pulled-up lines read low while any device pulls
  assign lockLine = !lockOe;
  assign errLine  = !errOe;

  // Idle levels
  initial begin
    vsyncPin  = 1'b1;
    pktToLink = 1'b0;
    strobe    = '0;
  end

  // One-cycle strobe: 0 act, 1 close, 2 packet, 3 reply, 4 bit time
  task automatic pulse(input int k);
    @(posedge clk);
    strobe <= 5'h01 << k;
    @(posedge clk);
    strobe <= '0;
  endtask

  // Packet strobe with its target flag held
  task automatic pkt(input logic toLink);
    @(posedge clk);
    pktToLink <= toLink;
    pulse(2);
  endtask

  // Vsync high for three cycles so the synchroniser settles, then falling
  task automatic openCh();
    @(posedge clk);
    vsyncPin <= 1'b1;
    repeat (3) @(posedge clk);
    vsyncPin <= 1'b0;
  endtask
endmodule

`default_nettype wire

// ---- testbench/test_control_channel_timers_and_mode.sv ----
/*
  Self-checking bench of the control-channel supervisor.
  Assumes the host model and the checker are compiled first.
*/
`default_nettype none

module test_control_channel_timers_and_mode;
  import ccst_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       ce = 1'b1;
  logic       regWrEn = 1'b0;
  logic [3:0] regIdx = '0;
  logic [9:0] regWrData = '0;
  logic [2:0] stat = 3'h0;
  logic [9:0] gpioIn = '0;
  logic [9:0] regRdData, gpioOut, gpioOe;
  logic [4:0] strobe;
  logic [2:0] driveBoost;
  logic       vsyncPin, pktToLink, ccen, i2cReqValid, uartFwdValid;
  logic       uartRspValid, bypassMode, lockOut, lockOe, errOut, errOe;
  logic       lockLine, errLine;
  int         fail_count = 0;
  int         compares = 0;

  always #5 clk = ~clk;

  ccst_control u_ccst_control (
    .clk, .rstn, .ce, .regWrEn, .regIdx, .regWrData, .regRdData,
    .vsyncPin, .hostActivity(strobe[0]), .closingFrame(strobe[1]),
    .pktValid(strobe[2]), .pktToLink, .periphRspValid(strobe[3]),
    .uartBitTick(strobe[4]), .linkLocked(stat[2]), .errorFlag(stat[1]),
    .shutdown(stat[0]), .gpioIn, .ccen, .i2cReqValid, .uartFwdValid,
    .uartRspValid, .bypassMode, .driveBoost, .lockOut, .lockOe, .errOut,
    .errOe, .gpioOut, .gpioOe);
  ccst_host_model u_ccst_host_model (
    .clk, .lockOe, .errOe, .lockLine, .errLine, .vsyncPin, .pktToLink,
    .strobe);

  // Compare and count
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Clock waits and register accesses
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] i, input logic [9:0] d);
    @(posedge clk);
    regWrEn   <= 1'b1;
    regIdx    <= i;
    regWrData <= d;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] i, input logic [9:0] e);
    @(posedge clk);
    regIdx <= i;
    cyc(1);
    chk(regRdData, e);
  endtask

  // Open the channel and wait for it, bounded
  task automatic waitOpen();
    u_ccst_host_model.openCh();
    for (int k = 0; k < 20 && !ccen; k++) cyc(1);
    chk(ccen, 1);
  endtask
  task automatic countUp(output int n);
    n = 0;
    while (ccen && n < 40000) begin
      cyc(1);
      n++;
    end
  endtask

  // Reset values, unmapped index, drive field
  task automatic t_regs();
    logic [3:0] ix [6] = '{IDX_WORD_WIDTH, IDX_START_CFG, IDX_END_CFG,
                           IDX_MODE, IDX_DRIVE, 4'hF};
    logic [9:0] rv [6] = '{10'h004, 10'h0A0, 10'h0A0, 10'h080, 10'h000,
                           10'h000};
    for (int k = 0; k < 6; k++) rd(ix[k], rv[k]);
    wr(IDX_DRIVE, 10'h0A0);
    rd(IDX_DRIVE, 10'h0A0);
    chk(driveBoost, 3'h5);
    @(posedge clk);
    ce <= 1'b0;
    wr(IDX_DRIVE, 10'h0E0);
    ce <= 1'b1;
    rd(IDX_DRIVE, 10'h0A0);
    chk(driveBoost, 3'h5);
  endtask

  // All lock, error and shutdown combinations
  task automatic t_status();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      stat <= i[2:0];
      cyc(2);
      chk(lockOe, !i[2] && !i[0]);
      chk(errOe, i[1] && !i[0]);
      chk({lockOut, errOut, lockLine, errLine},
          {2'b00, i[2] || i[0], !i[1] || i[0]});
    end
  endtask

  // Pin availability by word width, direction and readback
  task automatic t_gpio();
    wr(IDX_GPIO_DIR, 10'h3FF);
    wr(IDX_GPIO_LVL, 10'h3FF);
    cyc(1);
    chk(gpioOe, 10'h300);
    chk(gpioOut, 10'h300);
    wr(IDX_WORD_WIDTH, 10'h000);
    cyc(1);
    chk(gpioOe, 10'h3FF);
    wr(IDX_GPIO_DIR, 10'h000);
    gpioIn <= 10'h2A5;
    cyc(6);
    rd(IDX_GPIO_LVL, 10'h2A5);
    chk(gpioOe, 10'h000);
  endtask

  // Start timeout for flat, first doubled and default divider codes
  task automatic t_start();
    logic [9:0] cfg [3] = '{10'h0A0, 10'h002, 10'h051};
    int         exp [3] = '{1024, 48, 64};
    int         n;
    for (int i = 0; i < 3; i++) begin
      wr(IDX_START_CFG, cfg[i]);
      waitOpen();
      countUp(n);
      chk(n >= exp[i] - 2 && n <= exp[i] + 5, 1);
    end
  endtask

  // Activity holds the channel past a short start timeout
  task automatic t_end();
    int n;
    wr(IDX_START_CFG, 10'h000);
    wr(IDX_END_CFG, 10'h041);
    waitOpen();
    repeat (4) begin
      u_ccst_host_model.pulse(0);
      cyc(20);
    end
    chk(ccen, 1);
    u_ccst_host_model.pulse(0);
    countUp(n);
    chk(n >= 30 && n <= 37, 1);
  endtask

  // Closing frame ends the channel at once, rising vsync edge selected
  task automatic t_close();
    wr(IDX_MODE, 10'h088);
    u_ccst_host_model.openCh();
    cyc(1);
    chk(ccen, 1);
    u_ccst_host_model.pulse(0);
    u_ccst_host_model.pulse(1);
    cyc(3);
    chk(ccen, 0);
  endtask

  // Steering per mode, bypass refusals and comeback timer
  task automatic t_steer();
    wr(IDX_MODE, 10'h0C0);
    u_ccst_host_model.pkt(1'b0);
    #1 chk(i2cReqValid, 1);
    u_ccst_host_model.pkt(1'b1);
    #1 chk(i2cReqValid, 0);
    u_ccst_host_model.pulse(3);
    #1 chk(uartRspValid, 1);
    wr(IDX_MODE, 10'h080);
    u_ccst_host_model.pkt(1'b0);
    #1 chk(i2cReqValid, 0);
    wr(IDX_MODE, 10'h041);
    cyc(2);
    chk(bypassMode, 1);
    u_ccst_host_model.pkt(1'b0);
    #1 chk({uartFwdValid, i2cReqValid}, 2'b10);
    wr(IDX_DRIVE, 10'h0E0);
    rd(IDX_DRIVE, 10'h000);
    repeat (15) u_ccst_host_model.pulse(4);
    cyc(1);
    chk(bypassMode, 1);
    repeat (3) u_ccst_host_model.pulse(4);
    cyc(3);
    chk(bypassMode, 0);
    rd(IDX_MODE, 10'h001);
    rd(IDX_DRIVE, 10'h0A0);
    wr(IDX_MODE, 10'h040);
    repeat (20) u_ccst_host_model.pulse(4);
    cyc(2);
    chk(bypassMode, 1);
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_status();
    t_gpio();
    t_start();
    t_end();
    t_close();
    t_steer();
    give_verdict();
  end

  // Watchdog
  initial begin
    #100000;
    fail_count++;
    give_verdict();
  end
endmodule

`default_nettype wire
